// file: inc/codec_cfg.svh
// Constants for the symbol codec with stream cipher
`ifndef CODEC_CFG_SVH
`define CODEC_CFG_SVH

`define SYM_W            5
`define PAIR_W           10
`define LFSR_LEN         11
`define LFSR_TAP_A       11
`define LFSR_TAP_B       9
`define LFSR_SEED        11'h7FF
`define LINK_NOT_READY_SYM 5'h1F
`define VIOLATION_SYM    5'h18
`define HALT_SYM         5'h14
`define IDLE_CODE        5'h1F
`define QUIET_HYP        11'h000
`define QUIET_DATA       11'h000
`define IDLE_HYP         11'h7FF
`define IDLE_DATA        11'h7FF
`define HALT_HYP         11'h39C
`define HALT_DATA        11'h108
`define MASTER_HYP       11'h380
`define MASTER_DATA      11'h080
`define BUF_DEPTH        2

`endif

// file: inc/codec_pkg.sv
// Types shared by the symbol codec files
package codec_pkg;
  typedef logic [4:0] sym_t;
  typedef logic [9:0] pair_t;
  typedef enum logic [2:0] {
    LS_QUIET, LS_HALT, LS_MASTER, LS_NOISE, LS_IDLE, LS_ACTIVE
  } line_state_t;
endpackage : codec_pkg

// file: design/pair_buffer.sv
// Two-entry buffer with valid and ready on both sides
`timescale 1ns/1ps
`include "codec_cfg.svh"
module pair_buffer #(
  parameter int WIDTH = `PAIR_W,
  parameter int DEPTH = `BUF_DEPTH
) (
  input  wire logic             clk,
  input  wire logic             rst_n,
  input  wire logic [WIDTH-1:0] in_data,
  input  wire logic             in_valid,
  output logic                  in_ready,
  output logic [WIDTH-1:0]      out_data,
  output logic                  out_valid,
  input  wire logic             out_ready
);
  localparam int AW = (DEPTH > 1) ? $clog2(DEPTH) : 1;

  initial begin
    if (DEPTH < 2 || (DEPTH & (DEPTH - 1)) != 0) $error("pair_buffer: DEPTH must be a power of two >= 2");
  end

  logic [WIDTH-1:0] mem_ff [DEPTH];
  logic [AW-1:0]    wptr_ff;
  logic [AW-1:0]    rptr_ff;
  logic [AW:0]      cnt_ff;
  logic             ready_ff;
  logic             push;
  logic             pop;
  logic [AW:0]      nxt_cnt;

  assign push      = in_valid && ready_ff;
  assign pop       = out_valid && out_ready;
  assign out_valid = (cnt_ff != '0);
  assign out_data  = mem_ff[rptr_ff];
  assign in_ready  = ready_ff;
  assign nxt_cnt   = cnt_ff + (AW + 1)'(push) - (AW + 1)'(pop);

  // Storage needs no reset; valid comes only from the count
  always_ff @(posedge clk) begin
    if (push) mem_ff[wptr_ff] <= in_data;
  end

  // Pointers, count and a registered ready so full is honest
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      wptr_ff  <= '0;
      rptr_ff  <= '0;
      cnt_ff   <= '0;
      ready_ff <= 1'b0;
    end else begin
      if (push) wptr_ff <= wptr_ff + AW'(1);
      if (pop) rptr_ff <= rptr_ff + AW'(1);
      cnt_ff   <= nxt_cnt;
      ready_ff <= (nxt_cnt < (AW + 1)'(DEPTH));
    end
  end
endmodule : pair_buffer

// file: design/descrambler.sv
// Self-synchronising descrambler for one symbol pair per clock
`timescale 1ns/1ps
`include "codec_cfg.svh"
module descrambler
  import codec_pkg::*;
(
  input  wire logic  clk,
  input  wire logic  rst_n,
  input  wire logic  enable,
  input  wire logic  resync,
  input  wire logic  advance,
  input  wire pair_t s_pair,
  output pair_t      d_pair
);
  // Deduced data words kept at full width so that a single bit can be picked out
  localparam logic [`LFSR_LEN-1:0] QUIET_D  = `QUIET_DATA;
  localparam logic [`LFSR_LEN-1:0] IDLE_D   = `IDLE_DATA;
  localparam logic [`LFSR_LEN-1:0] HALT_D   = `HALT_DATA;
  localparam logic [`LFSR_LEN-1:0] MASTER_D = `MASTER_DATA;

  logic [`LFSR_LEN-1:0] gen_ff;
  logic [`LFSR_LEN-1:0] shist_ff;
  logic [`LFSR_LEN-1:0] hhist_ff;
  logic [`LFSR_LEN-1:0] nxt_gen;
  logic [`LFSR_LEN-1:0] nxt_shist;
  logic [`LFSR_LEN-1:0] nxt_hhist;

  // Bits go out first-symbol MSB first, so walk from bit 9 downward
  always_comb begin
    logic sb;
    logic hb;
    logic gout;
    logic gin;
    logic db;
    logic hit;
    logic ded;
    sb = 1'b0; hb = 1'b0; gout = 1'b0; gin = 1'b0; db = 1'b0; hit = 1'b0; ded = 1'b0;
    nxt_gen   = gen_ff;
    nxt_shist = shist_ff;
    nxt_hhist = hhist_ff;
    d_pair    = s_pair;
    if (enable) begin
      for (int i = `PAIR_W - 1; i >= 0; i--) begin
        sb   = s_pair[i];
        hb   = sb ^ nxt_shist[`LFSR_TAP_A-1] ^ nxt_shist[`LFSR_TAP_B-1];
        nxt_hhist = {nxt_hhist[`LFSR_LEN-2:0], hb};
        gout = nxt_gen[`LFSR_TAP_A-1] ^ nxt_gen[`LFSR_TAP_B-1];
        hit  = 1'b1;
        // Newest deduced bit of the recognised line-state pattern
        unique case (nxt_hhist)
          `QUIET_HYP:  ded = QUIET_D[0];
          `IDLE_HYP:   ded = IDLE_D[0];
          `HALT_HYP:   ded = HALT_D[0];
          `MASTER_HYP: ded = MASTER_D[0];
          default: begin
            ded = 1'b0;
            hit = 1'b0;
          end
        endcase
        // Once data is valid the generator runs open loop
        if (resync && hit) begin
          db  = ded;
          gin = ded ^ sb;
        end else begin
          db  = sb ^ gout;
          gin = gout;
        end
        nxt_gen   = {nxt_gen[`LFSR_LEN-2:0], gin};
        nxt_shist = {nxt_shist[`LFSR_LEN-2:0], sb};
        d_pair[i] = db;
      end
    end
  end

  // Generator and history state move only when a pair arrives
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      gen_ff   <= `LFSR_SEED;
      shist_ff <= '0;
      hhist_ff <= '0;
    end else if (advance) begin
      gen_ff   <= nxt_gen;
      shist_ff <= nxt_shist;
      hhist_ff <= nxt_hhist;
    end
  end
endmodule : descrambler

// file: design/symbol_codec.sv
// Symbol-pair 4B/5B codec with stream cipher scrambler and descrambler
//
// Contract
// - Decode five-bit codes, control bit on top
// - Decode both symbols of pair independently
// - Control and data code decode table
// - Halt and violation codes decode accordingly
// - Invalid symbol until link is established
// - Violation symbol on flagged input error
// - Buffer error in bad line state: invalid
// - Class flag selects decoder or transmit bypass; code bypasses only while link_ready is low, then decodes
// - Encode each symbol of pair independently
// - Control and data encode table
// - Invalid control inputs transmit idle code
// - Scrambler XORs each bit with generator
// - Descrambler XORs with identical local generator
// - Eleven-stage generator fed by stages 11,9
// - Hypothesis bit from delays eleven and nine
// - Four line-state hypothesis patterns recognised
// - No pattern: generator free-runs, output XORed
// - Pattern: deduced data, generator reloaded
// - Cipher enabled by pin OR bit
// - Resync only while no valid signal
`timescale 1ns/1ps
`include "codec_cfg.svh"
module symbol_codec
  import codec_pkg::*;
(
  input  wire logic        mclk,
  input  wire logic        rst_n,
  // Cipher, class and link control
  input  wire logic        cipher_enable_pin,
  input  wire logic        cipher_enable_bit,
  input  wire logic        class_s,
  input  wire logic        link_ready,
  // Receive side: code pairs from the receiver parts
  input  wire pair_t       rx_code,
  input  wire logic        rx_code_valid,
  input  wire logic        eb_error,
  input  wire logic        rx_code_error,
  input  wire line_state_t line_state,
  output pair_t            rx_pair,
  output logic             rx_pair_valid,
  output logic             descrambler_resync_request,
  // Transmit side: symbol pairs from the MAC
  input  wire pair_t       tx_pair,
  input  wire logic        tx_pair_valid,
  output logic             tx_pair_ready,
  output pair_t            tx_code,
  output logic             tx_code_valid,
  input  wire logic        tx_code_ready
);
  // A pair is exactly two symbols; the per-half loop below relies on it
  localparam int HALVES = `PAIR_W / `SYM_W;

  // Synchronised reset and cipher pin
  logic  rst_meta_ff;
  logic  rst_sync_ff;
  logic  pin_meta_ff;
  logic  pin_sync_ff;
  logic  cipher_on;
  // Transmit path
  pair_t buf_data;
  logic  buf_valid;
  logic  buf_ready;
  logic  tx_load;
  pair_t enc_pair;
  pair_t scr_pair;
  logic [`LFSR_LEN-1:0] scr_ff;
  logic [`LFSR_LEN-1:0] nxt_scr;
  // Receive path
  pair_t desc_pair;
  pair_t dec_pair;
  pair_t nxt_rx_pair;
  logic  resync;
  logic  bad_ls;

  // Symbol decode of one code group
  function automatic sym_t decode_sym(input sym_t code);
    unique case (code)
      // Control codes
      5'h00: decode_sym = 5'h10;
      5'h1F: decode_sym = 5'h17;
      5'h04: decode_sym = 5'h14;
      5'h18: decode_sym = 5'h1C;
      5'h11: decode_sym = 5'h13;
      5'h0D: decode_sym = 5'h1D;
      5'h07: decode_sym = 5'h11;
      5'h19: decode_sym = 5'h19;

      // Halt and violation codes, the line's error classes
      5'h01, 5'h02, 5'h08, 5'h10: decode_sym = `HALT_SYM;
      5'h03, 5'h05, 5'h06, 5'h0C: decode_sym = `VIOLATION_SYM;

      // Data codes, nibble in the low four bits
      5'h1E: decode_sym = 5'h00;
      5'h09: decode_sym = 5'h01;
      5'h14: decode_sym = 5'h02;
      5'h15: decode_sym = 5'h03;
      5'h0A: decode_sym = 5'h04;
      5'h0B: decode_sym = 5'h05;
      5'h0E: decode_sym = 5'h06;
      5'h0F: decode_sym = 5'h07;
      5'h12: decode_sym = 5'h08;
      5'h13: decode_sym = 5'h09;
      5'h16: decode_sym = 5'h0A;
      5'h17: decode_sym = 5'h0B;
      5'h1A: decode_sym = 5'h0C;
      5'h1B: decode_sym = 5'h0D;
      5'h1C: decode_sym = 5'h0E;
      5'h1D: decode_sym = 5'h0F;

      // All 32 codes are listed; this branch only keeps the case complete
      default: decode_sym = `VIOLATION_SYM;
    endcase
  endfunction : decode_sym

  // Symbol encode of one control-plus-nibble symbol
  function automatic sym_t encode_sym(input sym_t sym);
    unique case (sym)
      // Control symbols
      5'h10: encode_sym = 5'h00;
      5'h17: encode_sym = 5'h1F;
      5'h14: encode_sym = 5'h04;
      5'h1C: encode_sym = 5'h18;
      5'h13: encode_sym = 5'h11;
      5'h1D: encode_sym = 5'h0D;
      5'h11: encode_sym = 5'h07;
      5'h19: encode_sym = 5'h19;

      // Data symbols
      5'h00: encode_sym = 5'h1E;
      5'h01: encode_sym = 5'h09;
      5'h02: encode_sym = 5'h14;
      5'h03: encode_sym = 5'h15;
      5'h04: encode_sym = 5'h0A;
      5'h05: encode_sym = 5'h0B;
      5'h06: encode_sym = 5'h0E;
      5'h07: encode_sym = 5'h0F;
      5'h08: encode_sym = 5'h12;
      5'h09: encode_sym = 5'h13;
      5'h0A: encode_sym = 5'h16;
      5'h0B: encode_sym = 5'h17;
      5'h0C: encode_sym = 5'h1A;
      5'h0D: encode_sym = 5'h1B;
      5'h0E: encode_sym = 5'h1C;
      5'h0F: encode_sym = 5'h1D;

      // Unlisted control inputs must never reach the line as garbage
      default: encode_sym = `IDLE_CODE;
    endcase
  endfunction : encode_sym

  // Reset release through two flops
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      rst_meta_ff <= 1'b0;
      rst_sync_ff <= 1'b0;
    end else begin
      rst_meta_ff <= 1'b1;
      rst_sync_ff <= rst_meta_ff;
    end
  end

  // The enable pin is asynchronous to mclk
  // A pin change acts two cycles late; the control bit acts at once
  always_ff @(posedge mclk or negedge rst_sync_ff) begin
    if (!rst_sync_ff) begin
      pin_meta_ff <= 1'b0;
      pin_sync_ff <= 1'b0;
    end else begin
      pin_meta_ff <= cipher_enable_pin;
      pin_sync_ff <= pin_meta_ff;
    end
  end

  assign cipher_on = pin_sync_ff | cipher_enable_bit;

  // ---------------- Transmit path ----------------

  // Buffer absorbs a transmitter stall so no MAC pair is lost
  pair_buffer #(
    .WIDTH (`PAIR_W),
    .DEPTH (`BUF_DEPTH)
  ) u_tx_buf (
    .clk       (mclk),
    .rst_n     (rst_sync_ff),
    .in_data   (tx_pair),
    .in_valid  (tx_pair_valid),
    .in_ready  (tx_pair_ready),
    .out_data  (buf_data),
    .out_valid (buf_valid),
    .out_ready (buf_ready)
  );

  // Output stage takes a new pair when empty or being drained
  assign buf_ready = !tx_code_valid || tx_code_ready;
  assign tx_load   = buf_valid && buf_ready;

  // One encoder and one decoder per half; the halves never look at each other
  for (genvar h = 0; h < HALVES; h++) begin : g_half
    assign enc_pair[h*`SYM_W +: `SYM_W] = encode_sym(buf_data[h*`SYM_W +: `SYM_W]);
    assign dec_pair[h*`SYM_W +: `SYM_W] = decode_sym(desc_pair[h*`SYM_W +: `SYM_W]);
  end

  // Scrambler: generator steps once per bit, first symbol MSB first
  // Cipher off leaves the generator still, so both ends stay aligned
  always_comb begin
    logic gout;
    gout     = 1'b0;
    nxt_scr  = scr_ff;
    scr_pair = enc_pair;
    if (cipher_on) begin
      for (int i = `PAIR_W - 1; i >= 0; i--) begin
        gout        = nxt_scr[`LFSR_TAP_A-1] ^ nxt_scr[`LFSR_TAP_B-1];
        nxt_scr     = {nxt_scr[`LFSR_LEN-2:0], gout};
        scr_pair[i] = enc_pair[i] ^ gout;
      end
    end
  end

  // Generator advances only on pairs actually sent
  always_ff @(posedge mclk or negedge rst_sync_ff) begin
    if (!rst_sync_ff) begin
      scr_ff <= `LFSR_SEED;
    end else if (tx_load) begin
      scr_ff <= nxt_scr;
    end
  end

  // Registered transmit output, same latency with cipher on or off
  always_ff @(posedge mclk or negedge rst_sync_ff) begin
    if (!rst_sync_ff) begin
      tx_code       <= '0;
      tx_code_valid <= 1'b0;
    end else begin
      if (tx_load) tx_code <= scr_pair;
      if (buf_ready) tx_code_valid <= buf_valid;
    end
  end

  // ---------------- Receive path ----------------

  // Noise means no valid signal, so pattern resync may run
  // Other states count as locked; the generator then runs open loop
  assign resync = (line_state == LS_NOISE);
  assign bad_ls = (line_state == LS_QUIET) || (line_state == LS_HALT) ||
                  (line_state == LS_MASTER) || (line_state == LS_NOISE);

  descrambler u_desc (
    .clk     (mclk),
    .rst_n   (rst_sync_ff),
    .enable  (cipher_on),
    .resync  (resync),
    .advance (rx_code_valid),
    .s_pair  (rx_code),
    .d_pair  (desc_pair)
  );

  // Substitution order: link down, then buffer error, then code error
  always_comb begin
    if (!class_s) begin
      nxt_rx_pair = tx_pair;
      if (link_ready) begin
        nxt_rx_pair = dec_pair;
      end
    end else if (!link_ready) begin
      nxt_rx_pair = {`LINK_NOT_READY_SYM, `LINK_NOT_READY_SYM};
    end else if (eb_error && bad_ls) begin
      nxt_rx_pair = {`LINK_NOT_READY_SYM, `LINK_NOT_READY_SYM};
    end else if (eb_error || rx_code_error) begin
      nxt_rx_pair = {`VIOLATION_SYM, `VIOLATION_SYM};
    end else begin
      nxt_rx_pair = dec_pair;
    end
    // Invalid outranks violation, and both apply in bypass once the link is up
    if (class_s || link_ready) begin
      if (eb_error && bad_ls) nxt_rx_pair = {`LINK_NOT_READY_SYM, `LINK_NOT_READY_SYM};
      else if (link_ready && (eb_error || rx_code_error)) nxt_rx_pair = {`VIOLATION_SYM, `VIOLATION_SYM};
    end
  end

  // Registered receive output and resync flag
  // In bypass the output loads on every cycle, with the transmit pair only while link_ready is low
  always_ff @(posedge mclk or negedge rst_sync_ff) begin
    if (!rst_sync_ff) begin
      rx_pair                    <= {`LINK_NOT_READY_SYM, `LINK_NOT_READY_SYM};
      rx_pair_valid              <= 1'b0;
      descrambler_resync_request <= 1'b0;
    end else begin
      rx_pair_valid              <= rx_code_valid || !class_s;
      descrambler_resync_request <= resync;
      if (rx_code_valid || !class_s) rx_pair <= nxt_rx_pair;
    end
  end
endmodule : symbol_codec

// file: verification/symbol_codec_checker.sv
// Port-level assertions for the symbol codec
`timescale 1ns/1ps
module symbol_codec_checker
  import codec_pkg::*;
(
  input wire logic        mclk,
  input wire logic        rst_n,
  input wire logic        class_s,
  input wire logic        link_ready,
  input wire logic        rx_code_valid,
  input wire logic        eb_error,
  input wire logic        rx_code_error,
  input wire line_state_t line_state,
  input wire pair_t       rx_pair,
  input wire logic        rx_pair_valid,
  input wire logic        descrambler_resync_request,
  input wire pair_t       tx_pair,
  input wire logic        tx_pair_valid,
  input wire logic        tx_pair_ready,
  input wire pair_t       tx_code,
  input wire logic        tx_code_valid,
  input wire logic        tx_code_ready
);
  logic [2:0] live_ff;
  logic       rx_take;
  logic       eb_quiet;

  // Own release copy, one edge later than the design's, so no check sees reset leftovers
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) live_ff <= 3'h0;
    else        live_ff <= {live_ff[1:0], 1'b1};
  end

  // Receive-side causes
  assign rx_take  = class_s && rx_code_valid && link_ready;
  assign eb_quiet = eb_error && (line_state inside {LS_QUIET, LS_HALT, LS_MASTER, LS_NOISE});

  default clocking @(posedge mclk); endclocking
  default disable iff (!live_ff[2]);

  property p_valid_follows; class_s && rx_code_valid |=> rx_pair_valid; endproperty
  a_valid_follows: assert property (p_valid_follows)
    else $error("decoded pair valid missing");
  property p_valid_cause; class_s && $past(class_s) && rx_pair_valid |-> $past(rx_code_valid); endproperty
  a_valid_cause: assert property (p_valid_cause)
    else $error("decoded pair valid without input");
  property p_not_ready; class_s && rx_code_valid && !link_ready |=> rx_pair == 10'h3FF; endproperty
  a_not_ready: assert property (p_not_ready)
    else $error("link not ready but data decoded");
  property p_eb_invalid; rx_take && eb_quiet |=> rx_pair == 10'h3FF; endproperty
  a_eb_invalid: assert property (p_eb_invalid)
    else $error("buffer error in quiet line state not invalid");
  property p_violation; rx_take && (eb_error || rx_code_error) && !eb_quiet |=> rx_pair == 10'h318; endproperty
  a_violation: assert property (p_violation)
    else $error("input error not turned into violation");
  property p_bypass; !class_s && !link_ready |=> rx_pair == $past(tx_pair); endproperty
  a_bypass: assert property (p_bypass)
    else $error("bypass does not carry transmit pair");
  property p_resync; line_state == LS_NOISE |=> descrambler_resync_request; endproperty
  a_resync: assert property (p_resync)
    else $error("resync not requested without signal");
  property p_locked; line_state != LS_NOISE |=> !descrambler_resync_request; endproperty
  a_locked: assert property (p_locked)
    else $error("resync requested with valid signal");
  property p_tx_hold; tx_code_valid && !tx_code_ready |=> tx_code_valid && $stable(tx_code); endproperty
  a_tx_hold: assert property (p_tx_hold)
    else $error("code pair dropped during stall");
  property p_tx_answer; tx_pair_valid && tx_pair_ready && !tx_code_valid |-> ##[1:4] tx_code_valid; endproperty
  a_tx_answer: assert property (p_tx_answer)
    else $error("taken pair never reached output");

  // Main scenarios reached
  c_eb_invalid: cover property (rx_take && eb_quiet);
  c_tx_stall: cover property (tx_code_valid && !tx_code_ready);
  c_tx_full: cover property (tx_pair_valid && !tx_pair_ready);
  c_resync: cover property (descrambler_resync_request);
endmodule : symbol_codec_checker

// file: verification/code_sink.sv
// Stand-in for the serial transmitter part that takes encoded pairs
`timescale 1ns/1ps
module code_sink
  import codec_pkg::*;
(
  input  wire logic  mclk,
  input  wire logic  rst_n,
  input  wire logic  stall,
  input  wire pair_t tx_code,
  input  wire logic  tx_code_valid,
  output logic       tx_code_ready,
  output int         got_count
);
  pair_t      got_ff [0:63];
  int         cnt_ff;
  logic [1:0] beat_ff;

  // Capture every accepted pair in order; slow mode takes two cycles in four so the buffer fills
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      beat_ff <= 2'h0;
      cnt_ff  <= 0;
    end else begin
      beat_ff <= beat_ff + 2'h1;
      if (tx_code_valid && tx_code_ready) begin
        got_ff[cnt_ff[5:0]] <= tx_code;
        cnt_ff              <= cnt_ff + 1;
      end
    end
  end
  assign tx_code_ready = !stall || beat_ff[1];
  assign got_count     = cnt_ff;
endmodule : code_sink

// file: verification/symbol_codec_test.sv
// Self-checking bench for the symbol codec
`timescale 1ns/1ps
`define CHK(g, e) begin checked++; if ((g) !== (e)) begin n_mismatch++; \
  $display("ERROR %0t: got %h expected %h", $time, (g), (e)); end end
module symbol_codec_test
  import codec_pkg::*;
;
  logic        mclk = 0, rst_n = 0, cipher_enable_pin = 0, cipher_enable_bit = 0, stall = 0;
  logic        class_s = 1, link_ready = 1, rx_code_valid = 0, eb_error = 0, rx_code_error = 0;
  logic        tx_pair_valid = 0, rx_pair_valid, descrambler_resync_request, tx_pair_ready;
  logic        tx_code_valid, tx_code_ready;
  pair_t       rx_code = 0, tx_pair = 0, rx_pair, tx_code;
  line_state_t line_state = LS_ACTIVE;
  int          got_count, n_mismatch = 0, checked = 0;
  sym_t data_code [16] = '{5'h1E, 5'h09, 5'h14, 5'h15, 5'h0A, 5'h0B, 5'h0E, 5'h0F,
                           5'h12, 5'h13, 5'h16, 5'h17, 5'h1A, 5'h1B, 5'h1C, 5'h1D};
  sym_t ctl_code [8] = '{5'h00, 5'h1F, 5'h04, 5'h18, 5'h11, 5'h0D, 5'h07, 5'h19};
  sym_t ctl_sym [8]  = '{5'h10, 5'h17, 5'h14, 5'h1C, 5'h13, 5'h1D, 5'h11, 5'h19};
  line_state_t quiet_states [4] = '{LS_QUIET, LS_HALT, LS_MASTER, LS_NOISE};

  always #25 mclk = ~mclk;

  symbol_codec i_symbol_codec (.mclk(mclk), .rst_n(rst_n), .cipher_enable_pin(cipher_enable_pin),
    .cipher_enable_bit(cipher_enable_bit), .class_s(class_s), .link_ready(link_ready), .rx_code(rx_code),
    .rx_code_valid(rx_code_valid), .eb_error(eb_error), .rx_code_error(rx_code_error),
    .line_state(line_state), .rx_pair(rx_pair), .rx_pair_valid(rx_pair_valid),
    .descrambler_resync_request(descrambler_resync_request), .tx_pair(tx_pair),
    .tx_pair_valid(tx_pair_valid), .tx_pair_ready(tx_pair_ready), .tx_code(tx_code),
    .tx_code_valid(tx_code_valid), .tx_code_ready(tx_code_ready));
  code_sink i_code_sink (.mclk(mclk), .rst_n(rst_n), .stall(stall), .tx_code(tx_code),
    .tx_code_valid(tx_code_valid), .tx_code_ready(tx_code_ready), .got_count(got_count));

  // Expected decode: halt codes 01,02,08,10; whatever is left is a violation
  function automatic sym_t dec(input sym_t c);
    for (int k = 0; k < 16; k++) if (c == data_code[k]) return {1'b0, 4'(k)};
    for (int k = 0; k < 8; k++) if (c == ctl_code[k]) return ctl_sym[k];
    if (c inside {5'h01, 5'h02, 5'h08, 5'h10}) return 5'h14;
    return 5'h18;
  endfunction : dec

  // Expected encode: unlisted control inputs go out as idle
  function automatic sym_t enc(input sym_t d);
    if (!d[4]) return data_code[d[3:0]];
    for (int k = 0; k < 8; k++) if (d == ctl_sym[k]) return ctl_code[k];
    return 5'h1F;
  endfunction : enc

  task automatic tally_and_finish();
    if (n_mismatch == 0 && checked > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask : tally_and_finish

  task automatic do_reset();
    rst_n = 0;
    repeat (6) @(negedge mclk);
    rst_n = 1;
    repeat (4) @(negedge mclk);
  endtask : do_reset

  // One received pair; valid is left high so callers may stream back to back
  task automatic rx_one(input pair_t c, input logic eb, input logic er, input line_state_t ls, input pair_t exp);
    rx_code = c;
    eb_error = eb;
    rx_code_error = er;
    line_state = ls;
    rx_code_valid = 1;
    @(negedge mclk);
    `CHK(rx_pair_valid, 1'b1)
    `CHK(rx_pair, exp)
  endtask : rx_one

  // Offer one pair and hold it until the edge that takes it
  task automatic tx_put(input pair_t p);
    tx_pair = p;
    tx_pair_valid = 1;
    for (int k = 0; k < 50 && tx_pair_ready !== 1'b1; k++) @(negedge mclk);
    @(negedge mclk);
  endtask : tx_put

  task automatic wait_count(input int n);
    for (int k = 0; k < 300 && got_count < n; k++) @(negedge mclk);
    `CHK(got_count, n)
  endtask : wait_count

  task automatic t_decode();
    for (int i = 0; i < 32; i++)
      rx_one({i[4:0], 5'(31 - i)}, 0, 0, LS_ACTIVE, {dec(i[4:0]), dec(5'(31 - i))});
    rx_code_valid = 0;
  endtask : t_decode

  task automatic t_subst();
    link_ready = 0;
    rx_one(10'h3DE, 0, 0, LS_ACTIVE, 10'h3FF);
    link_ready = 1;
    for (int i = 0; i < 4; i++) rx_one(10'h3DE, 1, 0, quiet_states[i], 10'h3FF);
    rx_one(10'h3DE, 1, 0, LS_IDLE, 10'h318);
    rx_one(10'h3DE, 0, 1, LS_ACTIVE, 10'h318);
    rx_code_valid = 0;
    line_state = LS_ACTIVE;
  endtask : t_subst

  task automatic t_bypass();
    class_s = 0;
    link_ready = 0;
    tx_pair = 10'h2A5;
    repeat (2) @(negedge mclk);
    `CHK(rx_pair, 10'h2A5)
    class_s = 1;
    link_ready = 1;
  endtask : t_bypass

  // Every symbol value on both halves while the sink stalls; cipher off so codes come out plain
  task automatic t_encode();
    stall = 1;
    for (int i = 0; i < 32; i++) tx_put({i[4:0], 5'(31 - i)});
    tx_pair_valid = 0;
    wait_count(32);
    for (int i = 0; i < 32; i++)
      `CHK(i_code_sink.got_ff[i], {enc(i[4:0]), enc(5'(31 - i))})
    stall = 0;
  endtask : t_encode

  // Scrambled codes looped back into the receiver must decode to what was sent
  task automatic t_cipher(input logic by_pin);
    pair_t sent [8];
    int    diff;
    do_reset();
    diff = 0;
    cipher_enable_pin = by_pin;
    cipher_enable_bit = !by_pin;
    repeat (4) @(negedge mclk);
    for (int i = 0; i < 8; i++) begin
      sent[i] = {1'b0, 4'(i * 3), 1'b0, 4'(15 - i)};
      tx_put(sent[i]);
    end
    tx_pair_valid = 0;
    wait_count(8);
    for (int i = 0; i < 8; i++)
      if (i_code_sink.got_ff[i] !== {enc(sent[i][9:5]), enc(sent[i][4:0])}) diff++;
    `CHK(diff != 0, 1'b1)
    for (int i = 0; i < 8; i++) rx_one(i_code_sink.got_ff[i], 0, 0, LS_ACTIVE, sent[i]);
    rx_code_valid = 0;
    cipher_enable_pin = 0;
    cipher_enable_bit = 0;
  endtask : t_cipher

  // Idle scrambled from an unrelated generator state; noise lets the descrambler lock onto it
  task automatic t_resync();
    logic [10:0] g;
    pair_t       s;
    g = 11'h5A3;
    cipher_enable_bit = 1;
    repeat (2) @(negedge mclk);
    for (int p = 0; p < 8; p++) begin
      for (int i = 9; i >= 0; i--) begin
        s[i] = 1'b1 ^ g[10] ^ g[8];
        g    = {g[9:0], g[10] ^ g[8]};
      end
      if (p < 3) begin
        rx_code       = s;
        line_state    = LS_NOISE;
        rx_code_valid = 1;
        @(negedge mclk);
      end else begin
        rx_one(s, 0, 0, (p < 6) ? LS_NOISE : LS_ACTIVE, 10'h2F7);
      end
    end
    rx_code_valid = 0;
    line_state = LS_ACTIVE;
    cipher_enable_bit = 0;
  endtask : t_resync

  initial begin
    do_reset();
    t_decode();
    t_subst();
    t_bypass();
    t_encode();
    t_cipher(1'b0);
    t_cipher(1'b1);
    t_resync();
    tally_and_finish();
  end

  // Whole run needs well under a thousand cycles
  initial begin
    #(50 * 5000);
    n_mismatch++;
    tally_and_finish();
  end
endmodule : symbol_codec_test

bind symbol_codec symbol_codec_checker i_symbol_codec_checker (.mclk(mclk), .rst_n(rst_n),
  .class_s(class_s), .link_ready(link_ready), .rx_code_valid(rx_code_valid), .eb_error(eb_error),
  .rx_code_error(rx_code_error), .line_state(line_state), .rx_pair(rx_pair), .rx_pair_valid(rx_pair_valid),
  .descrambler_resync_request(descrambler_resync_request), .tx_pair(tx_pair), .tx_pair_valid(tx_pair_valid),
  .tx_pair_ready(tx_pair_ready), .tx_code(tx_code), .tx_code_valid(tx_code_valid),
  .tx_code_ready(tx_code_ready));
